// file: spi_peripheral_port_test.sv
/*
  Self-checking bench for the serial port against a queue model.
  Assumes the host model file is compiled first; inputs move on falling edges.
*/
`timescale 1ns/1ps

module spi_peripheral_port_test;
  import spp_pkg::*;
  logic CLOCK_I = 1'b0;
  logic SYS_RST_I = 1'b1;
  logic [31:0] gcr = 32'h0;
  logic [31:0] fmt = 32'h0;
  spp_word_type tx_word = 16'h0000;
  logic RX_READY_I = 1'b0;
  wire logic sclk, cs_n, mosi, miso, dout, oe, taken, rx_valid;
  spp_word_type rx_word;
  spp_status_type status;
  logic miso_last = 1'b0;
  logic stall = 1'b0;
  logic oe_seen, perr_seen;
  int taken_cnt, fails = 0, num_checks = 0;
  logic [15:0] exp_q[$];

  // 250 MHz clock
  initial begin
    forever #2 CLOCK_I = ~CLOCK_I;
  end

  spp_port u_dut (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .GLOBAL_CONTROL_REG_I(gcr),
    .FORMAT_REG_I(fmt), .SERIAL_CLOCK_IN_I(sclk), .CHIP_SELECT_N_I(cs_n),
    .HOST_OUT_DATA_I(mosi), .DEVICE_OUT_DATA_O(dout), .DEVICE_OUT_DATA_OE_O(oe),
    .TX_WORD_I(tx_word), .TX_TAKEN_O(taken), .RX_WORD_O(rx_word), .RX_VALID_O(rx_valid),
    .RX_READY_I(RX_READY_I), .STATUS_O(status));
  spp_host_model u_host (.clk_i(CLOCK_I), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso));

  // Undriven data line shows the inverse of its last level
  assign miso = oe ? dout : ~miso_last;

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Random user stall unless a full stall is asked for
  always @(negedge CLOCK_I) begin
    RX_READY_I <= stall ? 1'b0 : 1'($urandom);
  end

  // Sticky monitors and received-word comparison
  always @(posedge CLOCK_I) begin
    if (oe) miso_last <= dout;
    if (!SYS_RST_I) begin
      if (taken === 1'b1) taken_cnt++;
      if (oe !== 1'b0) oe_seen = 1'b1;
      if (status.period_error !== 1'b0) perr_seen = 1'b1;
      check("status bits", {status.frame_active, status.word_valid}, {oe, rx_valid});
      if (rx_valid === 1'b1 && RX_READY_I === 1'b1) begin
        if (exp_q.size() == 0) check("rx extra word", 1, 0);
        else check("rx word", rx_word, exp_q.pop_front());
      end
    end
  end

  // One frame with model update and end-of-frame checks
  task automatic frame(int nbits, int half, logic ctrl, logic pol, logic pha, int ps);
    logic [15:0] hw, dw, got;
    logic pre;
    int lim;
    hw = 16'($urandom);
    dw = 16'($urandom);
    lim = (ps == 0) ? 2 : ps + 1;
    if (lim < 7) lim = 7;
    @(negedge CLOCK_I);
    gcr = {31'h0, ctrl};
    fmt = {14'h0, pol, pha, 8'(ps), 8'h00};
    tx_word = dw;
    taken_cnt = 0;
    oe_seen = 1'b0;
    perr_seen = 1'b0;
    if (!ctrl && nbits == 16 && exp_q.size() < 3) exp_q.push_back(hw);
    u_host.xfer(hw, nbits, half, pol, got, pre);
    repeat (8) @(negedge CLOCK_I);
    if (!ctrl && nbits == 16) check("device word", got, dw);
    if (!ctrl) check("lead bit", pre, pha & dw[15]);
    check("tx taken count", taken_cnt, ctrl ? 0 : 1);
    check("output enabled", oe_seen, !ctrl);
    check("enable after frame", oe, 0);
    check("period error", perr_seen, !ctrl && (2 * half < lim));
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || rx_valid !== 1'b0) && n < 300) begin
      @(negedge CLOCK_I);
      n++;
    end
    check("drain done", n < 300, 1);
    if (n >= 300) give_verdict();
  endtask

  initial begin
    void'($urandom(87));
    repeat (20) @(negedge CLOCK_I);
    SYS_RST_I = 1'b0;
    repeat (2) @(negedge CLOCK_I);
    // Every phase and polarity, back to back
    for (int m = 0; m < 8; m++) frame(16, 6, 1'b0, m[1], m[0], $urandom_range(10));
    frame(16, 6, 1'b1, 1'b0, 1'b0, 0);
    frame(10, 6, 1'b0, 1'b0, 1'b1, 0);
    frame(16, 6, 1'b0, 1'b0, 1'b1, 0);
    frame(8, 3, 1'b0, 1'b0, 1'b0, 0);
    frame(8, 6, 1'b0, 1'b1, 1'b1, 20);
    drain();
    // Full stall: fourth word has no room and is dropped
    stall = 1'b1;
    for (int k = 0; k < 4; k++) frame(16, 6, 1'b0, k[0], k[1], 3);
    check("held words", exp_q.size(), 3);
    stall = 1'b0;
    drain();
    give_verdict();
  end
endmodule // spi_peripheral_port_test

// file: spp_buffer.sv
/*
  Two-entry valid/ready buffer carrying received words to the user.
  Assumes one clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
`include "spp_params.svh"

module spp_buffer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire spp_pkg::spp_word_type in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output spp_pkg::spp_word_type out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  import spp_pkg::*;

  spp_word_type mem_q [0:`SPP_BUF_DEPTH-1];
  logic wr_q;
  logic rd_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  // Handshake terms; full stalls the source
  assign in_ready_o = (count_q != 2'h2);
  assign out_valid_o = (count_q != 2'h0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  no_overfill_a: assert property (@(posedge clk_i) disable iff (rst_i) count_q <= 2'h2)
    else $error("buffer count above depth");
endmodule // spp_buffer

// file: spp_host_model.sv
/*
  Behavioural SPI host that drives select, clock and data into the port.
  Assumes the bench clock is given; every pin changes on its falling edge.
*/
`timescale 1ns/1ps

module spp_host_model (
  input wire logic clk_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // Idle: deselected, clock parked
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One frame; half is the clock half period in bench cycles
  // Data goes out on the leading edge and is taken on the trailing one
  task automatic xfer(input logic [15:0] tx, input int nbits, input int half,
                      input logic pol, output logic [15:0] rx, output logic pre);
    rx = 16'h0000;
    @(negedge clk_i);
    sclk_o = pol;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    repeat (4 * half) @(negedge clk_i);
    pre = miso_i;
    for (int i = 0; i < nbits; i++) begin
      sclk_o = ~pol;
      mosi_o = tx[15-i];
      repeat (half) @(negedge clk_i);
      sclk_o = pol;
      rx[15-i] = miso_i;
      repeat (half) @(negedge clk_i);
    end
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released line must not keep its value
    repeat (2 * half) @(negedge clk_i);
  endtask
endmodule // spp_host_model

// file: spp_params.svh
/*
  Constants for the serial peripheral port: bit positions, reset values, timing counts.
  Assumes inclusion by the package and by design files of this block only.
*/
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

`define SPP_CTRL_MODE_BIT 0
`define SPP_FMT_PHASE_BIT 16
`define SPP_FMT_POL_BIT 17
`define SPP_FMT_PS_LSB 8
`define SPP_FMT_PS_MSB 15
`define SPP_WORD_BITS 16
`define SPP_CTRL_RESET 32'h00000000
`define SPP_FMT_RESET 32'h00000000
`define SPP_CLK_PERIOD_PS 4000
`define SPP_MIN_SCLK_PS 25000
`define SPP_MIN_SCLK_CYC ((`SPP_MIN_SCLK_PS + `SPP_CLK_PERIOD_PS - 1) / `SPP_CLK_PERIOD_PS)
`define SPP_BUF_DEPTH 2

`endif

// file: spp_pkg.sv
/*
  Types shared by the serial peripheral port.
  Assumes spp_params.svh is on the include path.
*/
`include "spp_params.svh"

package spp_pkg;
  // Received or transmitted word
  typedef logic [`SPP_WORD_BITS-1:0] spp_word_type;

  // Status sent out of the port
  typedef struct packed {
    logic frame_active;
    logic word_valid;
    logic period_error;
  } spp_status_type;

  typedef enum logic [1:0] {
    SPP_IDLE,
    SPP_SHIFT,
    SPP_DONE
  } spp_state_type;
endpackage

// file: spp_port.sv
/*
  Serial peripheral port, target mode: host drives clock, select and data in.
  Assumes all serial pins are asynchronous to CLOCK_I and are oversampled;
  the serial clock must be well below a quarter of CLOCK_I.
*/
// Overview of operation
// - Acts as target, drives only data out, while controller-mode bit 0 is clear.
// - Format bit 16 picks clock phase 0 or phase 1.
// - Format bit 17 picks which serial clock edge is active.
// - Serial clock period at least prescale+1, or two, subsystem clocks and 25 ns.
// - Data out changes after rising edge at polarity 0, falling at polarity 1.
`timescale 1ns/1ps
`include "spp_params.svh"

module spp_port (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic [31:0] GLOBAL_CONTROL_REG_I,
  input wire logic [31:0] FORMAT_REG_I,
  input wire logic SERIAL_CLOCK_IN_I,
  input wire logic CHIP_SELECT_N_I,
  input wire logic HOST_OUT_DATA_I,
  output logic DEVICE_OUT_DATA_O,
  output logic DEVICE_OUT_DATA_OE_O,
  input wire spp_pkg::spp_word_type TX_WORD_I,
  output logic TX_TAKEN_O,
  output spp_pkg::spp_word_type RX_WORD_O,
  output logic RX_VALID_O,
  input wire logic RX_READY_I,
  output spp_pkg::spp_status_type STATUS_O
);
  import spp_pkg::*;

  logic [2:0] sclk_q;
  logic [2:0] cs_q;
  logic [1:0] mosi_q;
  logic target_mode;
  logic phase;
  logic pol;
  logic sclk_rise;
  logic sclk_fall;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic shift_edge;
  logic shift_now;
  logic tx_msb;
  logic cs_active;
  logic [4:0] bit_cnt_q;
  spp_word_type rx_sh_q;
  spp_word_type tx_sh_q;
  spp_state_type state_q;
  logic push_q;
  spp_word_type push_word_q;
  logic buf_ready;
  spp_word_type buf_data;
  logic buf_valid;
  logic [8:0] per_cnt_q;
  logic [8:0] min_per;
  logic per_err_q;
  logic out_q;
  logic oe_q;
  logic taken_q;
  logic rx_valid_q;
  spp_word_type rx_word_q;

  // Least serial period in system clocks for the given prescale
  function automatic logic [8:0] min_period(input logic [7:0] ps);
    logic [8:0] p;
    p = (ps == 8'h00) ? 9'h002 : ({1'b0, ps} + 9'h001);
    if (p < 9'(`SPP_MIN_SCLK_CYC)) begin
      p = 9'(`SPP_MIN_SCLK_CYC);
    end
    return p;
  endfunction

  assign target_mode = ~GLOBAL_CONTROL_REG_I[`SPP_CTRL_MODE_BIT];
  assign phase = FORMAT_REG_I[`SPP_FMT_PHASE_BIT];
  assign pol = FORMAT_REG_I[`SPP_FMT_POL_BIT];
  assign min_per = min_period(FORMAT_REG_I[`SPP_FMT_PS_MSB:`SPP_FMT_PS_LSB]);

  // Pin synchronisers; edge logic reads only stages 1 and 2
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sclk_q <= 3'h0;
      cs_q <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], SERIAL_CLOCK_IN_I};
      cs_q <= {cs_q[1:0], CHIP_SELECT_N_I};
      mosi_q <= {mosi_q[0], HOST_OUT_DATA_I};
    end
  end

  // Leading edge is rising at polarity 0, falling at polarity 1
  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign lead_edge = pol ? sclk_fall : sclk_rise;
  assign trail_edge = pol ? sclk_rise : sclk_fall;
  // Data moves on the leading edge and is taken on the trailing one, either phase
  assign sample_edge = trail_edge;
  assign shift_edge = lead_edge;
  assign cs_active = ~cs_q[2] & target_mode;
  // Phase 1 shows the first bit at select, so its first leading edge holds
  assign shift_now = (state_q == SPP_SHIFT) && cs_active && shift_edge &&
    (!phase || bit_cnt_q != 5'h00);
  assign tx_msb = TX_WORD_I[`SPP_WORD_BITS-1];

  // Frame sequencing and bit counting
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_q <= SPP_IDLE;
      bit_cnt_q <= 5'h00;
      rx_sh_q <= '0;
      push_q <= 1'b0;
      push_word_q <= '0;
    end else begin
      push_q <= 1'b0;
      case (state_q)
        SPP_IDLE: begin
          bit_cnt_q <= 5'h00;
          if (cs_active) begin
            state_q <= SPP_SHIFT;
          end
        end
        SPP_SHIFT: begin
          if (!cs_active) begin
            state_q <= SPP_IDLE;
            bit_cnt_q <= 5'h00;
          end else if (sample_edge) begin
            rx_sh_q <= {rx_sh_q[`SPP_WORD_BITS-2:0], mosi_q[1]};
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == 5'(`SPP_WORD_BITS - 1)) begin
              push_q <= 1'b1;
              push_word_q <= {rx_sh_q[`SPP_WORD_BITS-2:0], mosi_q[1]};
              state_q <= SPP_DONE;
            end
          end
        end
        SPP_DONE: begin
          // Extra clocks ignored until select rises again
          if (!cs_active) begin
            state_q <= SPP_IDLE;
            bit_cnt_q <= 5'h00;
          end
        end
        default: state_q <= SPP_IDLE;
      endcase
    end
  end

  // Transmit shifter; word is latched at frame start, MSB first
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tx_sh_q <= '0;
      out_q <= 1'b0;
      taken_q <= 1'b0;
    end else begin
      taken_q <= 1'b0;
      if (state_q == SPP_IDLE && cs_active) begin
        // Phase 0 keeps data low until the first leading edge
        tx_sh_q <= phase ? {TX_WORD_I[`SPP_WORD_BITS-2:0], 1'b0} : TX_WORD_I;
        out_q <= phase & tx_msb;
        taken_q <= 1'b1;
      end else if (shift_now) begin
        out_q <= tx_sh_q[`SPP_WORD_BITS-1];
        tx_sh_q <= {tx_sh_q[`SPP_WORD_BITS-2:0], 1'b0};
      end
    end
  end

  // Drive data out only while selected in target mode
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= cs_active;
    end
  end

  // Serial period check against the prescale limit
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      per_cnt_q <= 9'h000;
      per_err_q <= 1'b0;
    end else if (!cs_active) begin
      per_cnt_q <= 9'h000;
      per_err_q <= 1'b0;
    end else if (lead_edge) begin
      if (bit_cnt_q != 5'h00 && per_cnt_q < min_per - 9'h001) begin
        per_err_q <= 1'b1;
      end
      per_cnt_q <= 9'h000;
    end else if (per_cnt_q != 9'h1FF) begin
      per_cnt_q <= per_cnt_q + 9'h001;
    end
  end

  // Receive buffer absorbs user stalls; a fourth unread word is dropped
  spp_buffer u_buf (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .in_data_i(push_word_q),
    .in_valid_i(push_q),
    .in_ready_o(buf_ready),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(!rx_valid_q || RX_READY_I)
  );

  // Output register stage; valid never waits on ready, so a waiting user cannot lock it
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_valid_q <= 1'b0;
      rx_word_q <= '0;
    end else if (!rx_valid_q || RX_READY_I) begin
      rx_valid_q <= buf_valid;
      rx_word_q <= buf_data;
    end
  end

  assign DEVICE_OUT_DATA_O = out_q;
  assign DEVICE_OUT_DATA_OE_O = oe_q;
  assign TX_TAKEN_O = taken_q;
  assign RX_WORD_O = rx_word_q;
  assign RX_VALID_O = rx_valid_q;
  assign STATUS_O = '{frame_active: oe_q, word_valid: rx_valid_q, period_error: per_err_q};

  oe_follows_mode_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !target_mode |=> !DEVICE_OUT_DATA_OE_O) else $error("output driven in controller mode");
  cnt_clear_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !cs_active && state_q != SPP_IDLE |=> bit_cnt_q == 5'h00) else $error("count not cleared");
  word_push_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    state_q == SPP_SHIFT && cs_active && sample_edge && bit_cnt_q == 5'h0F |=> push_q)
    else $error("word not pushed");
  out_edge_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    $changed(out_q) && $past(state_q) == SPP_SHIFT
    |-> ($past(pol) && $past(sclk_fall)) || (!$past(pol) && $past(sclk_rise)))
    else $error("data out moved off its edge");
  phase_edge_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    state_q == SPP_IDLE && cs_active |=> out_q == ($past(phase) && $past(tx_msb)))
    else $error("first data bit wrong for phase");
  pol_edge_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    pol && sclk_q[1] && !sclk_q[2] |-> trail_edge) else $error("polarity 1 edge wrong");
  period_flag_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    cs_active && lead_edge && bit_cnt_q != 5'h00 && per_cnt_q < min_per - 9'h001
    |=> per_err_q) else $error("short period not flagged");
  taken_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    state_q == SPP_IDLE && cs_active |=> TX_TAKEN_O) else $error("tx word not taken");
  frame_c: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I) push_q);
  stall_c: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I) !buf_ready);
  perr_c: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I) per_err_q);
endmodule // spp_port
